// ==== dv/step_host.sv ====
// Host model: step pulses with direction and resolution pins.
// Assumes sleep_n is the device wake pin, sampled on pclk.
`timescale 1ns/1ps
module step_host #(
   parameter int WAKE_CYCLES = 100000,
   parameter int PULSE_CYCLES = 100
) (
   // Clock and wake watch
   input wire logic pclk,
   input wire logic sleep_n,
   // Pins to the device
   output logic step,
   output logic rotation_sense,
   output logic [2:0] sel_pins
);
   int awake_q;
   initial begin
      step = 1'b0;
      rotation_sense = 1'b0;
      sel_pins = 3'h0;
   end
   always_ff @(posedge pclk) begin
      if (!sleep_n) begin
         awake_q <= 0;
      end else if (awake_q < WAKE_CYCLES) begin
         awake_q <= awake_q + 1;
      end
   end
   // Pins settle well ahead of the edge to meet setup
   task automatic preset(input logic ccw, input logic [2:0] sel);
      @(posedge pclk);
      rotation_sense <= ccw;
      sel_pins <= sel;
      repeat (20) @(posedge pclk);
   endtask
   task automatic issue(input logic ccw, input logic [2:0] sel);
      preset(ccw, sel);
      while (awake_q < WAKE_CYCLES) @(posedge pclk);
      step <= 1'b1;
      repeat (PULSE_CYCLES) @(posedge pclk);
      step <= 1'b0;
      repeat (PULSE_CYCLES) @(posedge pclk);
   endtask
endmodule

// ==== dv/stepper_drive_props.sv ====
// Checker of the stepper translator and chopper top ports.
// Assumes one pclk domain; bound to the top at the foot.
`timescale 1ns/1ps
module stepper_drive_props (
   // Clock, reset, bus
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // Pins
   input wire logic step,
   input wire logic translator_reset_n,
   input wire logic sleep_n,
   input wire logic outputs_disable,
   input wire logic over_temp,
   input wire logic charge_pump_rail_undervolt,
   input wire logic sink_gate_regulator_fault,
   input wire logic undervoltage_lockout,
   input wire logic [1:0] sense_trip,
   // Bridge side
   input stepper_drive_pkg::fet_gates_s [1:0] fet_gate,
   input stepper_drive_pkg::dac_level_t [1:0] phase_dac_level,
   input wire logic charge_pump_enable,
   input wire logic current_regulator_enable
);
   logic kill_any;
   logic [7:0] held_q;
   assign kill_any = outputs_disable | over_temp | charge_pump_rail_undervolt |
      sink_gate_regulator_fault | undervoltage_lockout | !translator_reset_n | !sleep_n;
   // Cycles bridge 0 has shown positive drive, saturating
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         held_q <= 8'h00;
      end else if (fet_gate[0] != 4'h9) begin
         held_q <= 8'h00;
      end else if (held_q != 8'hff) begin
         held_q <= held_q + 8'h01;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence access_s;
      psel && penable && !pready;
   endsequence
   sequence step_seen_s;
      $past(step, 2) && !$past(step, 3);
   endsequence
   apb_answer_a: assert property (access_s |=> pready)
      else $error("no ready after access");
   apb_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   ready_cause_a: assert property ($rose(pready) |-> $past(psel && penable))
      else $error("ready without access");
   // Level output trails the held index by one register stage
   hold_home_a: assert property ((!translator_reset_n) [*3] |->
      fet_gate == '0 && phase_dac_level == 16'hb4b4) else $error("hold not at home");
   kill_gates_a: assert property (kill_any [*2] |-> fet_gate == '0)
      else $error("gates on while disabled");
   sleep_power_a: assert property (!sleep_n |=> !charge_pump_enable &&
      !current_regulator_enable) else $error("power on in sleep");
   lockout_reg_a: assert property (undervoltage_lockout |=> !current_regulator_enable)
      else $error("regulator on in lockout");
   dac_step_cause_a: assert property ($changed(phase_dac_level) &&
      phase_dac_level != 16'hb4b4 |-> step_seen_s) else $error("level moved without step");
   blank_trip_a: assert property (sense_trip[0] && fet_gate[0] == 4'h9 &&
      held_q < 8'd50 && !kill_any |-> ##2 fet_gate[0] == 4'h9) else $error("trip not blanked");
endmodule

bind stepper_drive stepper_drive_props chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .step(step),
   .translator_reset_n(translator_reset_n), .sleep_n(sleep_n),
   .outputs_disable(outputs_disable), .over_temp(over_temp),
   .charge_pump_rail_undervolt(charge_pump_rail_undervolt),
   .sink_gate_regulator_fault(sink_gate_regulator_fault),
   .undervoltage_lockout(undervoltage_lockout), .sense_trip(sense_trip),
   .fet_gate(fet_gate), .phase_dac_level(phase_dac_level),
   .charge_pump_enable(charge_pump_enable), .current_regulator_enable(current_regulator_enable));

// ==== dv/stepper_drive_tb.sv ====
// Self-checking bench of the stepper translator and chopper.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ps
module stepper_drive_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic step, rotation_sense, outputs_disable, translator_reset_n, sleep_n;
   logic [2:0] sel_pins;
   logic [1:0] sense_trip, load_current_zero, phase_positive, decay_mixed;
   logic off_time_resistor_pin_high, over_temp, charge_pump_rail_undervolt;
   logic sink_gate_regulator_fault, undervoltage_lockout;
   logic charge_pump_enable, current_regulator_enable;
   stepper_drive_pkg::fet_gates_s [1:0] fet_gate;
   stepper_drive_pkg::dac_level_t [1:0] phase_dac_level;
   int fail_count = 0;
   int checked = 0;
   int cyc = 0;
   logic [2:0] sel_t [6] = '{3'b000, 3'b100, 3'b010, 3'b110, 3'b111, 3'b000};
   logic [5:0] idx_t [6] = '{6'd24, 6'd32, 6'd36, 6'd38, 6'd39, 6'd23};

   stepper_drive dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .step(step), .rotation_sense(rotation_sense),
      .microstep_select_a(sel_pins[2]), .microstep_select_b(sel_pins[1]),
      .microstep_select_c(sel_pins[0]), .outputs_disable(outputs_disable),
      .translator_reset_n(translator_reset_n), .sleep_n(sleep_n), .sense_trip(sense_trip),
      .load_current_zero(load_current_zero),
      .off_time_resistor_pin_high(off_time_resistor_pin_high), .over_temp(over_temp),
      .charge_pump_rail_undervolt(charge_pump_rail_undervolt),
      .sink_gate_regulator_fault(sink_gate_regulator_fault),
      .undervoltage_lockout(undervoltage_lockout), .fet_gate(fet_gate),
      .phase_dac_level(phase_dac_level), .phase_positive(phase_positive),
      .decay_mixed(decay_mixed), .charge_pump_enable(charge_pump_enable),
      .current_regulator_enable(current_regulator_enable));
   // Short wake wait keeps the run brief
   step_host #(.WAKE_CYCLES(300), .PULSE_CYCLES(100)) host_u (.pclk(pclk), .sleep_n(sleep_n),
      .step(step), .rotation_sense(rotation_sense), .sel_pins(sel_pins));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         finish_test();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the bench cycle ceiling ends a stalled wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp,
      input logic exp_err);
      apb(1'b0, a, 32'h0);
      check(rd & m, exp);
      check({31'h0, err}, {31'h0, exp_err});
   endtask

   task automatic pulse_trip();
      sense_trip <= 2'b01;
      @(posedge pclk);
      sense_trip <= 2'b00;
   endtask

   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, outputs_disable, off_time_resistor_pin_high} = '0;
      {over_temp, charge_pump_rail_undervolt, sink_gate_regulator_fault} = '0;
      {undervoltage_lockout, sense_trip, load_current_zero, paddr, pwdata} = '0;
      {translator_reset_n, sleep_n} = 2'b11;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      check({phase_dac_level, phase_positive, decay_mixed}, 20'hb4b4f);
      rd_chk(12'h000, 32'h0007_033f, 32'h0000_0308, 1'b0);
      rd_chk(12'h004, 32'hff, 32'h19, 1'b0);
      rd_chk(12'h00c, 32'hffff, 32'd3030, 1'b0);
      apb(1'b1, 12'h008, 32'hffff_ffff);
      check({31'h0, err}, 32'h1);
      rd_chk(12'h010, 32'hffff_ffff, 32'h0, 1'b1);
      off_time_resistor_pin_high <= 1'b1;
      repeat (4) @(posedge pclk);
      rd_chk(12'h00c, 32'hffff, 32'd3000, 1'b0);
      off_time_resistor_pin_high <= 1'b0;
      apb(1'b1, 12'h004, 32'h1);
      repeat (4) @(posedge pclk);
      rd_chk(12'h00c, 32'hffff, 32'd121, 1'b0);
      repeat (100) @(posedge pclk);
      check(fet_gate, 8'h99);
      pulse_trip();
      repeat (10) @(posedge pclk);
      check(fet_gate[0], 4'h6);
      repeat (60) @(posedge pclk);
      check(fet_gate[0], 4'h5);
      repeat (80) @(posedge pclk);
      check(fet_gate[0], 4'h9);
      pulse_trip();
      repeat (5) @(posedge pclk);
      check(fet_gate[0], 4'h9);
      repeat (120) @(posedge pclk);
      pulse_trip();
      repeat (4) @(posedge pclk);
      load_current_zero <= 2'b01;
      repeat (4) @(posedge pclk);
      check(fet_gate[0], 4'h0);
      load_current_zero <= 2'b00;
      repeat (200) @(posedge pclk);
      for (int i = 0; i < 6; i++) begin
         host_u.issue(i < 5, sel_t[i]);
         rd_chk(12'h000, 32'h3f, {26'h0, idx_t[i]}, 1'b0);
         if (i == 0) check({phase_dac_level, phase_positive, decay_mixed}, 20'hb4b48);
         if (i == 1) check({phase_dac_level, phase_positive, decay_mixed}, 20'h00ff2);
      end
      host_u.preset(1'b1, 3'b111);
      rd_chk(12'h000, 32'h3f, 32'd23, 1'b0);
      for (int k = 0; k < 4; k++) begin
         {outputs_disable, over_temp, charge_pump_rail_undervolt,
            sink_gate_regulator_fault} <= 4'h8 >> k;
         repeat (3) @(posedge pclk);
         check(fet_gate, 8'h00);
         rd_chk(12'h000, 32'h17_0000, 32'h10_0000 | ((k == 0) ? 32'h0 : 32'h1_0000 << (k - 1)),
            1'b0);
         if (k == 0) begin
            host_u.issue(1'b1, 3'b000);
            rd_chk(12'h000, 32'h3f, 32'd39, 1'b0);
         end
         {outputs_disable, over_temp, charge_pump_rail_undervolt,
            sink_gate_regulator_fault} <= 4'h0;
         repeat (3) @(posedge pclk);
      end
      translator_reset_n <= 1'b0;
      host_u.issue(1'b1, 3'b000);
      check(fet_gate, 8'h00);
      rd_chk(12'h000, 32'h10_003f, 32'h10_0008, 1'b0);
      translator_reset_n <= 1'b1;
      host_u.issue(1'b1, 3'b000);
      undervoltage_lockout <= 1'b1;
      repeat (3) @(posedge pclk);
      check({fet_gate, current_regulator_enable}, 9'h000);
      rd_chk(12'h000, 32'h18_003f, 32'h18_0008, 1'b0);
      undervoltage_lockout <= 1'b0;
      host_u.issue(1'b1, 3'b000);
      sleep_n <= 1'b0;
      repeat (3) @(posedge pclk);
      check({charge_pump_enable, current_regulator_enable, fet_gate}, 10'h000);
      sleep_n <= 1'b1;
      repeat (3) @(posedge pclk);
      check({charge_pump_enable, current_regulator_enable}, 2'b11);
      rd_chk(12'h000, 32'h3f, 32'd8, 1'b0);
      host_u.issue(1'b1, 3'b000);
      rd_chk(12'h000, 32'h3f, 32'd24, 1'b0);
      finish_test();
   end
endmodule

// ==== verilog/stepper_drive.sv ====
// Step/direction translator with fixed off-time PWM chopper for two bridges, APB status/config.
// Assumes pins and comparator flags are synchronous to pclk and each lasts several cycles.
`timescale 1ns/1ps
`include "stepper_drive_map.svh"

module stepper_drive (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Host control pins
   input wire logic step,
   input wire logic rotation_sense,
   input wire logic microstep_select_a,
   input wire logic microstep_select_b,
   input wire logic microstep_select_c,
   input wire logic outputs_disable,
   input wire logic translator_reset_n,
   input wire logic sleep_n,
   // Analog front-end flags
   input wire logic [1:0] sense_trip,
   input wire logic [1:0] load_current_zero,
   input wire logic off_time_resistor_pin_high,
   input wire logic over_temp,
   input wire logic charge_pump_rail_undervolt,
   input wire logic sink_gate_regulator_fault,
   input wire logic undervoltage_lockout,
   // Bridge drive
   output stepper_drive_pkg::fet_gates_s [1:0] fet_gate,
   output stepper_drive_pkg::dac_level_t [1:0] phase_dac_level,
   output logic [1:0] phase_positive,
   output logic [1:0] decay_mixed,
   output logic charge_pump_enable,
   output logic current_regulator_enable
);

   // Quarter-wave magnitude, full scale 255, sixteenth-step spacing
   function automatic stepper_drive_pkg::dac_level_t sine_mag(input logic [4:0] r);
      stepper_drive_pkg::dac_level_t m;
      m = 8'h00;
      unique case (r)
         5'h00: m = 8'h00;
         5'h01: m = 8'h19;
         5'h02: m = 8'h32;
         5'h03: m = 8'h4a;
         5'h04: m = 8'h62;
         5'h05: m = 8'h78;
         5'h06: m = 8'h8e;
         5'h07: m = 8'ha2;
         5'h08: m = 8'hb4;
         5'h09: m = 8'hc5;
         5'h0a: m = 8'hd4;
         5'h0b: m = 8'he1;
         5'h0c: m = 8'hec;
         5'h0d: m = 8'hf4;
         5'h0e: m = 8'hfa;
         5'h0f: m = 8'hfe;
         5'h10: m = 8'hff;
         default: m = 8'hff;
      endcase
      return m;
   endfunction

   function automatic stepper_drive_pkg::dac_level_t sin_level(
      input stepper_drive_pkg::step_index_t idx);
      logic [4:0] r;
      r = {1'b0, idx[3:0]};
      if (idx[4]) begin
         r = 5'h10 - r;
      end
      return sine_mag(r);
   endfunction

   // Polarity: high when the sine at this index is positive or zero-crossing upward
   function automatic logic sin_positive(input stepper_drive_pkg::step_index_t idx);
      return ~idx[5];
   endfunction

   // Phase 1 follows the cosine, phase 2 the sine
   function automatic stepper_drive_pkg::step_index_t phase_index(
      input stepper_drive_pkg::step_index_t idx, input int unsigned ph);
      return (ph == 0) ? stepper_drive_pkg::step_index_t'(idx + 6'h10) : idx;
   endfunction

   // Input edge and output gating
   logic step_q;
   logic step_rise;
   logic hold_home;
   logic outs_off;

   assign step_rise = step & ~step_q;
   assign hold_home = ~translator_reset_n | ~sleep_n | undervoltage_lockout;
   assign outs_off = hold_home | outputs_disable | over_temp | charge_pump_rail_undervolt
                     | sink_gate_regulator_fault;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step_q <= 1'b0;
      end else begin
         step_q <= step;
      end
   end

   // Translator
   stepper_drive_pkg::step_index_t pos_q;
   stepper_drive_pkg::step_index_t pos_d;
   stepper_drive_pkg::step_index_t incr;
   stepper_drive_pkg::dac_level_t [1:0] dac_q;
   stepper_drive_pkg::dac_level_t [1:0] dac_d;
   stepper_drive_pkg::dac_level_t [1:0] home_dac;
   logic [1:0] pos_pol_q;
   logic [1:0] pol_d;
   logic [1:0] home_pol;
   logic [1:0] mixed_q;
   logic [1:0] mixed_d;

   always_comb begin
      unique case ({microstep_select_a, microstep_select_b, microstep_select_c}) // R2 R3
         3'b000: incr = 6'h10;
         3'b100: incr = 6'h08;
         3'b010: incr = 6'h04;
         3'b110: incr = 6'h02;
         3'b111: incr = 6'h01;
         default: incr = 6'h01;
      endcase
      // Wraps modulo 64 by width
      if (rotation_sense) begin // R4 R5
         pos_d = pos_q + incr; // R22
      end else begin
         pos_d = pos_q - incr; // R22
      end
      for (int i = 0; i < 2; i++) begin
         dac_d[i] = sin_level(phase_index(pos_d, i)); // R20
         pol_d[i] = sin_positive(phase_index(pos_d, i));
         mixed_d[i] = dac_d[i] < dac_q[i]; // R8
         home_dac[i] = sin_level(phase_index(`HOME_INDEX, i)); // R21
         home_pol[i] = sin_positive(phase_index(`HOME_INDEX, i));
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos_q <= `HOME_INDEX; // R6
         dac_q <= {8'hb4, 8'hb4}; // R6 R21
         pos_pol_q <= 2'b11;
         mixed_q <= 2'b11; // R6
      end else if (hold_home) begin
         // Step edges ignored while held; wake-up restarts from Home
         pos_q <= `HOME_INDEX; // R7 R14 R16
         dac_q <= home_dac; // R7
         pos_pol_q <= home_pol;
         mixed_q <= 2'b11; // R6
      end else if (step_rise) begin
         // Runs whatever the output gating short of a hold, so a disabled bridge still tracks steps
         pos_q <= pos_d; // R1 R13
         dac_q <= dac_d; // R1
         pos_pol_q <= pol_d; // R1
         mixed_q <= mixed_d; // R8
      end
   end

   // Off-time configuration
   logic [7:0] resistor_kohm_q;
   logic [15:0] off_cycles_q;
   logic [15:0] slow_start_q;
   logic [31:0] off_time_resistor_pin_cycles;
   logic [19:0] fast_prod;

   assign off_time_resistor_pin_cycles = ({24'h0, resistor_kohm_q} * 32'(`OHMS_PER_KOHM) * 32'(`CLK_MHZ))
                        / 32'(`OFF_TIME_RESISTOR_PIN_OHMS_PER_US);
   assign fast_prod = {4'h0, off_cycles_q} * 20'(`FAST_NUM);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         off_cycles_q <= 16'(`OFF_CYCLES_DEFAULT);
         slow_start_q <= 16'h0000;
      end else begin
         if (off_time_resistor_pin_high || resistor_kohm_q == 8'h00) begin
            off_cycles_q <= 16'(`OFF_CYCLES_DEFAULT); // R11
         end else begin
            off_cycles_q <= off_time_resistor_pin_cycles[15:0]; // R11
         end
         // Remaining count below which mixed decay turns slow
         slow_start_q <= off_cycles_q - fast_prod[`FAST_SHIFT +: 16]; // R9
      end
   end

   // Chopper, one per bridge
   stepper_drive_pkg::chop_state_e [1:0] chop_q;
   logic [1:0][15:0] off_cnt_q;
   logic [1:0][7:0] blank_cnt_q;
   logic [1:0] zero_seen_q;
   stepper_drive_pkg::fet_gates_s [1:0] gate_q;

   for (genvar b = 0; b < 2; b++) begin : g_bridge
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            chop_q[b] <= stepper_drive_pkg::CHOP_DRIVE;
            off_cnt_q[b] <= 16'h0000;
            blank_cnt_q[b] <= 8'(`BLANK_CYCLES);
            zero_seen_q[b] <= 1'b0;
         end else if (outs_off) begin
            chop_q[b] <= stepper_drive_pkg::CHOP_DRIVE; // R7 R13 R14 R15 R16
            off_cnt_q[b] <= 16'h0000;
            blank_cnt_q[b] <= 8'(`BLANK_CYCLES); // R12
            zero_seen_q[b] <= 1'b0;
         end else begin
            unique case (chop_q[b])
               stepper_drive_pkg::CHOP_DRIVE: begin
                  if (blank_cnt_q[b] != 8'h00) begin
                     blank_cnt_q[b] <= blank_cnt_q[b] - 8'h01; // R12
                  end else if (sense_trip[b]) begin
                     chop_q[b] <= stepper_drive_pkg::CHOP_OFF; // R10
                     off_cnt_q[b] <= off_cycles_q; // R11
                     zero_seen_q[b] <= 1'b0;
                  end
               end
               stepper_drive_pkg::CHOP_OFF: begin
                  if (load_current_zero[b]) begin
                     zero_seen_q[b] <= 1'b1; // R19
                  end
                  if (off_cnt_q[b] <= 16'h0001) begin
                     chop_q[b] <= stepper_drive_pkg::CHOP_DRIVE;
                     blank_cnt_q[b] <= 8'(`BLANK_CYCLES); // R12
                  end else begin
                     off_cnt_q[b] <= off_cnt_q[b] - 16'h0001;
                  end
               end
            endcase
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            gate_q[b] <= '0;
         end else if (outs_off) begin
            gate_q[b] <= '0; // R7 R13 R14 R15 R16
         end else if (chop_q[b] == stepper_drive_pkg::CHOP_DRIVE) begin
            // Diagonal pair sets the current direction
            gate_q[b] <= pos_pol_q[b] ? 4'b1001 : 4'b0110; // R10
         end else if (zero_seen_q[b] || load_current_zero[b]) begin
            gate_q[b] <= '0; // R19
         end else if (mixed_q[b] && off_cnt_q[b] > slow_start_q) begin
            // Fast decay: opposite diagonal conducts back to the supply
            gate_q[b] <= pos_pol_q[b] ? 4'b0110 : 4'b1001; // R9 R10 R19
         end else begin
            // Slow decay: both sinks recirculate, sources off
            gate_q[b] <= 4'b0101; // R9 R10 R19
         end
      end
   end

   // Drive and supply outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_dac_level <= {8'hb4, 8'hb4};
         phase_positive <= 2'b11;
         decay_mixed <= 2'b11;
         charge_pump_enable <= 1'b0;
         current_regulator_enable <= 1'b0;
      end else begin
         phase_dac_level <= dac_q; // R20
         phase_positive <= pos_pol_q;
         decay_mixed <= mixed_q;
         charge_pump_enable <= sleep_n; // R16
         current_regulator_enable <= sleep_n & ~undervoltage_lockout; // R16
      end
   end

   assign fet_gate = gate_q;

   // APB slave: one wait state, error on unmapped address or read-only write
   logic access;
   logic mapped;
   logic writable;
   logic [31:0] rd_word;

   assign access = psel & penable & ~pready;

   always_comb begin
      mapped = 1'b1;
      writable = 1'b0;
      rd_word = 32'h0000_0000;
      unique case (paddr)
         `REG_STATUS: begin
            rd_word[`ST_POS_LSB +: 6] = pos_q;
            rd_word[`ST_MIXED_LSB +: 2] = mixed_q;
            rd_word[`ST_OVERTEMP_BIT] = over_temp;
            rd_word[`ST_PUMP_UV_BIT] = charge_pump_rail_undervolt;
            rd_word[`ST_REG_FAULT_BIT] = sink_gate_regulator_fault;
            rd_word[`ST_UNDERVOLTAGE_LOCKOUT_BIT] = undervoltage_lockout;
            rd_word[`ST_OUTS_OFF_BIT] = outs_off;
         end
         `REG_OFFTIME: begin
            writable = 1'b1;
            rd_word[7:0] = resistor_kohm_q;
         end
         `REG_DAC: begin
            rd_word[15:0] = {dac_q[1], dac_q[0]};
            rd_word[`DAC_POL_LSB +: 2] = pos_pol_q;
         end
         `REG_OFFCYC: begin
            rd_word[15:0] = off_cycles_q;
         end
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= access;
         pslverr <= access & (~mapped | (pwrite & ~writable));
         if (access && !pwrite) begin
            prdata <= rd_word;
         end else if (access) begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         resistor_kohm_q <= `RESISTOR_KOHM_RESET;
      end else if (access && pwrite && writable) begin
         resistor_kohm_q <= pwdata[7:0];
      end
   end

endmodule

// ==== verilog/stepper_drive_map.svh ====
// Offsets, field positions, reset values and timing counts of the stepper translator.
// Assumes a single 100 MHz pclk; included by bare name.
//
// What this block does
// R1: Each step rising edge advances position one increment and updates both DACs and polarities.
// R2: Three select pins decode to full, half, quarter, eighth or sixteenth increment.
// R3: Select pins are sampled only at a step rising edge.
// R4: Rotation-sense low steps clockwise, high steps counterclockwise.
// R5: Rotation-sense is sampled only at a step rising edge.
// R6: Power-on or reset loads Home into both DACs and selects mixed decay.
// R7: Reset low holds Home, switches every FET off and ignores step edges.
// R8: Falling DAC level selects mixed decay; rising or equal selects slow decay.
// R9: Mixed decay runs fast decay for 31.25% of off-time, then slow decay.
// R10: Drive diagonal pair until comparator trips, then turn off per decay mode.
// R11: Off-time is 30 us with pin high, else resistor divided by 825 us.
// R12: Comparator outputs are masked for about 1 us after each output switch.
// R13: Output-disable high turns all FETs off; translator keeps running regardless.
// R14: Over-temperature or pump undervoltage turns FETs off; lockout also forces Home.
// R15: A sink-gate regulator fault turns every FET off.
// R16: Sleep low disables FETs, regulator and pump; wake-up returns to Home.
// R17: Controller waits at least 1 ms after wake-up before stepping.
// R18: Controller holds step high and low for at least 1 us each.
// R19: Decay uses synchronous rectification, dropped as load current nears zero.
// R20: Each phase DAC scales the trip threshold to the tabulated percentage.
// R21: Home is the 45 degree step, both phases at 70.71 percent.
// R22: Translator is a 64-entry sixteenth-step index wrapping modulo 64.
`ifndef STEPPER_DRIVE_MAP_SVH
`define STEPPER_DRIVE_MAP_SVH

`define CLK_MHZ 100
`define T_OFF_DEFAULT_US 30
`define T_BLANK_US 1
`define OFF_CYCLES_DEFAULT (`T_OFF_DEFAULT_US * `CLK_MHZ)
`define BLANK_CYCLES (`T_BLANK_US * `CLK_MHZ)
`define OFF_TIME_RESISTOR_PIN_OHMS_PER_US 825
`define OHMS_PER_KOHM 1000
`define FAST_NUM 5
`define FAST_SHIFT 4
`define HOME_INDEX 6'h08

`define REG_STATUS 12'h000
`define REG_OFFTIME 12'h004
`define REG_DAC 12'h008
`define REG_OFFCYC 12'h00c

`define RESISTOR_KOHM_RESET 8'h19

`define ST_POS_LSB 0
`define ST_MIXED_LSB 8
`define ST_OVERTEMP_BIT 16
`define ST_PUMP_UV_BIT 17
`define ST_REG_FAULT_BIT 18
`define ST_UNDERVOLTAGE_LOCKOUT_BIT 19
`define ST_OUTS_OFF_BIT 20
`define DAC_POL_LSB 16

`endif

// ==== verilog/stepper_drive_pkg.sv ====
// Types shared by the stepper translator and chopper.
// Assumes nothing beyond a SystemVerilog compiler.
package stepper_drive_pkg;
   typedef struct packed {
      logic src_a;
      logic snk_a;
      logic src_b;
      logic snk_b;
   } fet_gates_s;

   typedef enum logic {CHOP_DRIVE, CHOP_OFF} chop_state_e;

   typedef logic [5:0] step_index_t;
   typedef logic [7:0] dac_level_t;
endpackage
